// [rtl/bus_setup_params.svh]
// constants for the bus setup and self-test control block
// assumes inclusion by the instrument end, the sequencer, the checker and the testbench
`ifndef BUS_SETUP_PARAMS_SVH
`define BUS_SETUP_PARAMS_SVH
`define ADDR_MAX        5'h1E
`define MODULE_COUNT    6'h3F
`define STB_INTERNAL    8'h61
`define STB_OP_COMPLETE 8'h42
`define KEY_MODE        4'h4
`define KEY_TERM        4'h5
`define KEY_ADDR        4'h6
`define CFG_RESET_MODE  2'h0
`define CFG_RESET_TERM  1'h1
`define CFG_RESET_ADDR  5'h00
`endif

// [rtl/bus_setup_pkg.sv]
// types shared by the keypad end, the controller end and the link
// assumes no surroundings beyond the compiler
package bus_setup_pkg;
	typedef enum logic [1:0] {
		MODE_OFF_BUS,
		MODE_TALK_ONLY,
		MODE_LISTEN_ONLY,
		MODE_TALK_LISTEN
	} bus_mode_t;
	typedef enum logic [1:0] {
		EDIT_NONE,
		EDIT_MODE,
		EDIT_TERM,
		EDIT_ADDR
	} edit_field_t;
	typedef enum logic [2:0] {
		TCMD_NONE,
		TCMD_START,
		TCMD_TEST,
		TCMD_RESUME,
		TCMD_ABORT,
		TCMD_EVENT_QUERY
	} test_cmd_t;
endpackage

// [rtl/bus_link_if.sv]
// link between the instrument end and the bus controller end
// assumes one shared clock; wired-bus details reduced to a strobed command
// and a status byte with its service request level
`timescale 1ns/1ns
interface bus_link_if;
	import bus_setup_pkg::*;
	logic        cmd_valid;
	test_cmd_t   cmd;
	logic        srq;
	logic [7:0]  status_byte;
	logic [5:0]  event_module;
	logic        event_valid;
	modport device (
		input  cmd_valid, cmd,
		output srq, status_byte, event_module, event_valid
	);
	modport controller (
		output cmd_valid, cmd,
		input  srq, status_byte, event_module, event_valid
	);
endinterface

// [rtl/selftest_seq.sv]
// self-test sequencer stepping through the circuit modules
// assumes module pass/fail comes from the instrument on the same clock
`timescale 1ns/1ns
`include "bus_setup_params.svh"
module selftest_seq (
	// clock, reset, enable
	input  wire logic                  mclk_in,
	input  wire logic                  rst_in,
	input  wire logic                  ce_in,
	// commands
	input  wire logic                  start_in,
	input  wire logic                  resume_in,
	input  wire logic                  abort_in,
	// module under test
	input  wire logic                  fault_in,
	output logic      [5:0]            module_out,
	// state
	output logic                       running_out,
	output logic                       halted_out,
	output logic                       done_out,
	output logic                       fault_event_out
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_HALT
	} st_state_t;
	st_state_t  state_reg;
	logic [5:0] module_reg;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg       <= ST_RUN;
			module_reg      <= 6'h00;
			done_out        <= 1'b0;
			fault_event_out <= 1'b0;
		end else if (ce_in) begin
			done_out        <= 1'b0;
			fault_event_out <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (start_in) begin
						state_reg  <= ST_RUN;
						module_reg <= 6'h00;
					end
				end
				ST_RUN: begin
					if (fault_in) begin
						state_reg       <= ST_HALT;
						fault_event_out <= 1'b1;
					end else if (module_reg == `MODULE_COUNT - 6'h01) begin
						state_reg <= ST_IDLE;
						done_out  <= 1'b1;
					end else begin
						module_reg <= module_reg + 6'h01;
					end
				end
				ST_HALT: begin
					if (resume_in) begin
						if (module_reg == `MODULE_COUNT - 6'h01) begin
							state_reg <= ST_IDLE;
							done_out  <= 1'b1;
						end else begin
							state_reg  <= ST_RUN;
							module_reg <= module_reg + 6'h01;
						end
					end else if (abort_in) begin
						state_reg <= ST_IDLE;
						done_out  <= 1'b1;
					end
				end
			endcase
		end
	end

	assign module_out  = module_reg;
	assign running_out = (state_reg == ST_RUN);
	assign halted_out  = (state_reg == ST_HALT);
endmodule

// [rtl/bus_setup_device.sv]
// instrument end: keypad bus setup selection and power-up self-test
// assumes keypad presses arrive as one-cycle pulses from a debouncer on
// mclk_in; nonvolatile storage is outside and loaded through nv_* ports
`timescale 1ns/1ns
`include "bus_setup_params.svh"
module bus_setup_device (
	// clock, reset, enable
	input  wire logic                    mclk_in,
	input  wire logic                    rst_in,
	input  wire logic                    ce_in,
	// keypad and remote state
	input  wire logic                    menu_toggle_key_in,
	input  wire logic [3:0]              key_in,
	input  wire logic                    key_valid_in,
	input  wire logic                    remote_lockout_in,
	// nonvolatile storage
	input  wire bus_setup_pkg::bus_mode_t nv_mode_in,
	input  wire logic                    nv_term_in,
	input  wire logic [4:0]              nv_addr_in,
	output logic                         nv_write_out,
	// self-test module result
	input  wire logic                    fault_in,
	output logic                         wave_mem_init_out,
	output logic                         panel_restore_out,
	// display
	output logic                         menu_active_out,
	output logic                         menu_lamp_out,
	output logic                         ident_msg_out,
	output logic                         rejected_update_prompt_out,
	output bus_setup_pkg::edit_field_t   edit_field_out,
	output logic                         prompt_blink_out,
	output bus_setup_pkg::bus_mode_t     show_mode_out,
	output logic                         show_term_out,
	output logic [4:0]                   show_addr_out,
	// active configuration
	output bus_setup_pkg::bus_mode_t     mode_out,
	output logic                         term_lf_out,
	output logic [4:0]                   addr_out,
	// link
	bus_link_if.device                   link
);
	import bus_setup_pkg::*;

	logic        menu_reg;
	edit_field_t edit_reg;
	bus_mode_t   mode_reg, mode_next, pend_mode_reg;
	logic        term_reg, pend_term_reg;
	logic [4:0]  addr_reg, pend_addr_reg;
	logic        loaded_reg;
	logic        st_start, st_resume, st_abort;
	logic        st_halted, st_done, st_fault;
	logic [5:0]  st_module;

	function automatic logic [4:0] addr_step(input logic [4:0] a);
		addr_step = (a >= `ADDR_MAX) ? 5'h00 : a + 5'h01;
	endfunction

	assign st_start  = link.cmd_valid && (link.cmd == TCMD_START || link.cmd == TCMD_TEST);
	assign st_resume = link.cmd_valid && link.cmd == TCMD_RESUME;
	assign st_abort  = link.cmd_valid && link.cmd == TCMD_ABORT && st_halted;

	selftest_seq u_seq (
		.mclk_in         (mclk_in),
		.rst_in          (rst_in),
		.ce_in           (ce_in),
		.start_in        (st_start),
		.resume_in       (st_resume),
		.abort_in        (st_abort),
		.fault_in        (fault_in),
		.module_out      (st_module),
		.running_out     (),
		.halted_out      (st_halted),
		.done_out        (st_done),
		.fault_event_out (st_fault)
	);

	// menu open and close
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			menu_reg <= 1'b0;
			edit_reg <= EDIT_NONE;
			rejected_update_prompt_out <= 1'b0;
		end else if (ce_in) begin
			if (menu_toggle_key_in) begin
				menu_reg <= !menu_reg;
				edit_reg <= EDIT_NONE;
				rejected_update_prompt_out <= menu_reg && remote_lockout_in;
			end else if (menu_reg && key_valid_in) begin
				unique case (key_in)
					`KEY_MODE: edit_reg <= EDIT_MODE;
					`KEY_TERM: edit_reg <= EDIT_TERM;
					`KEY_ADDR: edit_reg <= EDIT_ADDR;
					default:   edit_reg <= edit_reg;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pend_mode_reg <= MODE_OFF_BUS;
			pend_term_reg <= `CFG_RESET_TERM;
			pend_addr_reg <= `CFG_RESET_ADDR;
		end else if (ce_in) begin
			if (!menu_reg) begin
				pend_mode_reg <= mode_reg;
				pend_term_reg <= term_reg;
				pend_addr_reg <= addr_reg;
			end else if (key_valid_in && !menu_toggle_key_in) begin
				if (key_in == `KEY_MODE && edit_reg == EDIT_MODE)
					pend_mode_reg <= bus_mode_t'(pend_mode_reg + 2'h1);
				if (key_in == `KEY_TERM && edit_reg == EDIT_TERM)
					pend_term_reg <= !pend_term_reg;
				if (key_in == `KEY_ADDR && edit_reg == EDIT_ADDR)
					pend_addr_reg <= addr_step(pend_addr_reg);
			end
		end
	end

	always_comb begin
		mode_next = mode_reg;
		if (!loaded_reg)
			mode_next = nv_mode_in;
		else if (menu_reg && menu_toggle_key_in && !remote_lockout_in)
			mode_next = pend_mode_reg;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			loaded_reg   <= 1'b0;
			mode_reg     <= MODE_OFF_BUS;
			term_reg     <= `CFG_RESET_TERM;
			addr_reg     <= `CFG_RESET_ADDR;
			nv_write_out <= 1'b0;
		end else if (ce_in) begin
			loaded_reg   <= 1'b1;
			mode_reg     <= mode_next;
			nv_write_out <= 1'b0;
			if (!loaded_reg) begin
				term_reg <= nv_term_in;
				addr_reg <= nv_addr_in;
			end else if (menu_reg && menu_toggle_key_in && !remote_lockout_in) begin
				term_reg     <= pend_term_reg;
				addr_reg     <= pend_addr_reg;
				nv_write_out <= 1'b1;
			end
		end
	end

	// display and config outputs
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			menu_active_out  <= 1'b0;
			menu_lamp_out    <= 1'b0;
			ident_msg_out    <= 1'b0;
			edit_field_out   <= EDIT_NONE;
			prompt_blink_out <= 1'b0;
			show_mode_out    <= MODE_OFF_BUS;
			show_term_out    <= 1'b0;
			show_addr_out    <= 5'h00;
			mode_out         <= MODE_OFF_BUS;
			term_lf_out      <= 1'b0;
			addr_out         <= 5'h00;
		end else if (ce_in) begin
			menu_active_out  <= menu_reg;
			menu_lamp_out    <= menu_reg;
			ident_msg_out    <= menu_reg;
			edit_field_out   <= edit_reg;
			prompt_blink_out <= menu_reg && edit_reg != EDIT_NONE;
			show_mode_out    <= pend_mode_reg;
			show_term_out    <= pend_term_reg;
			show_addr_out    <= pend_addr_reg;
			mode_out         <= mode_reg;
			term_lf_out      <= term_reg;
			addr_out         <= addr_reg;
		end
	end

	// service request and event reporting
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			link.srq          <= 1'b0;
			link.status_byte  <= 8'h00;
			link.event_module <= 6'h00;
			link.event_valid  <= 1'b0;
			wave_mem_init_out <= 1'b0;
			panel_restore_out <= 1'b0;
		end else if (ce_in) begin
			wave_mem_init_out <= st_done;
			panel_restore_out <= st_done;
			link.event_valid  <= 1'b0;
			if (st_fault) begin
				link.srq         <= 1'b1;
				link.status_byte <= `STB_INTERNAL;
			end else if (st_done) begin
				link.srq         <= 1'b1;
				link.status_byte <= `STB_OP_COMPLETE;
			end else if (link.cmd_valid && link.cmd == TCMD_EVENT_QUERY) begin
				link.srq          <= 1'b0;
				link.event_module <= st_module;
				link.event_valid  <= st_halted;
			end
		end
	end
endmodule

// [rtl/bus_ctrl_end.sv]
// controller end: turns user test requests into strobed link commands
// assumes user requests are one-cycle pulses on mclk_in
`timescale 1ns/1ns
module bus_ctrl_end (
	// clock, reset, enable
	input  wire logic                  mclk_in,
	input  wire logic                  rst_in,
	input  wire logic                  ce_in,
	// user side
	input  wire logic                  req_in,
	input  wire bus_setup_pkg::test_cmd_t req_cmd_in,
	output logic                       srq_out,
	output logic [7:0]                 status_out,
	output logic [5:0]                 fault_module_out,
	output logic                       fault_module_valid_out,
	// link
	bus_link_if.controller             link
);
	import bus_setup_pkg::*;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			link.cmd_valid <= 1'b0;
			link.cmd       <= TCMD_NONE;
		end else if (ce_in) begin
			link.cmd_valid <= req_in;
			link.cmd       <= req_in ? req_cmd_in : TCMD_NONE;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			srq_out                <= 1'b0;
			status_out             <= 8'h00;
			fault_module_out       <= 6'h00;
			fault_module_valid_out <= 1'b0;
		end else if (ce_in) begin
			srq_out                <= link.srq;
			status_out             <= link.status_byte;
			fault_module_valid_out <= link.event_valid;
			if (link.event_valid)
				fault_module_out <= link.event_module;
		end
	end
endmodule

// [sim/bus_link_assertions.sv]
// checker for the link: service request, status byte and event query
// assumes one clock for both ends; signals taken straight from the interface
`timescale 1ns/1ns
`include "bus_setup_params.svh"
module bus_link_assertions (
	// clock and reset
	input  wire logic                     mclk_in,
	input  wire logic                     rst_in,
	// link
	input  wire logic                     cmd_valid,
	input  wire bus_setup_pkg::test_cmd_t cmd,
	input  wire logic                     srq,
	input  wire logic [7:0]               status_byte,
	input  wire logic [5:0]               event_module,
	input  wire logic                     event_valid
);
	import bus_setup_pkg::*;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	logic q;
	assign q = cmd_valid && (cmd == TCMD_EVENT_QUERY);
	property p_srq_code;
		srq |-> (status_byte == `STB_INTERNAL) || (status_byte == `STB_OP_COMPLETE);
	endproperty
	a_srq_code: assert property (p_srq_code) else $error("bad status code");
	property p_query_answer;
		q && srq && (status_byte == `STB_INTERNAL) |=> event_valid;
	endproperty
	a_query_answer: assert property (p_query_answer) else $error("no event answer");
	property p_event_cause;
		event_valid |-> $past(q);
	endproperty
	a_event_cause: assert property (p_event_cause) else $error("event without query");
	property p_event_range;
		event_valid |-> event_module < `MODULE_COUNT;
	endproperty
	a_event_range: assert property (p_event_range) else $error("module out of range");
	property p_srq_stands;
		srq && !q |=> srq;
	endproperty
	a_srq_stands: assert property (p_srq_stands) else $error("request dropped");
	property p_query_clears;
		q && srq |-> ##[1:3] !srq;
	endproperty
	a_query_clears: assert property (p_query_clears) else $error("request not cleared");
	property p_event_pulse;
		event_valid |=> !event_valid;
	endproperty
	a_event_pulse: assert property (p_event_pulse) else $error("event too long");
	property p_status_stable;
		srq && $past(srq) |-> $stable(status_byte);
	endproperty
	a_status_stable: assert property (p_status_stable) else $error("status moved");
endmodule

// [sim/bus_setup_and_selftest_control_tb_top.sv]
// testbench: keypad bus setup and self-test, both ends joined by the link
// assumes the design and package files are compiled first
`timescale 1ns/1ns
`include "bus_setup_params.svh"
module bus_setup_and_selftest_control_tb_top;
	import bus_setup_pkg::*;
	logic        mclk_in, rst_in, ce_in, mkey, kvalid, lock, nv_term, fault, req;
	logic [3:0]  key;
	logic [4:0]  nv_addr, show_addr_out, addr_out;
	bus_mode_t   nv_mode, show_mode_out, mode_out;
	test_cmd_t   req_cmd;
	edit_field_t edit_field_out;
	logic        nvw, winit, rest, act, lamp, ident, rej, blink, show_term_out, term_lf_out;
	logic        srq_out, fmv, s_nvw, s_init, s_rest, s_mod;
	logic [7:0]  status_out;
	logic [5:0]  fmod, got_mod;
	int          n_errors, comparisons, n;
	bus_link_if u_bus_link_if ();
	bus_setup_device u_bus_setup_device (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
		.menu_toggle_key_in(mkey), .key_in(key), .key_valid_in(kvalid),
		.remote_lockout_in(lock), .nv_mode_in(nv_mode), .nv_term_in(nv_term),
		.nv_addr_in(nv_addr), .nv_write_out(nvw), .fault_in(fault), .wave_mem_init_out(winit),
		.panel_restore_out(rest), .menu_active_out(act), .menu_lamp_out(lamp),
		.ident_msg_out(ident), .rejected_update_prompt_out(rej), .edit_field_out(edit_field_out),
		.prompt_blink_out(blink), .show_mode_out(show_mode_out), .show_term_out(show_term_out),
		.show_addr_out(show_addr_out), .mode_out(mode_out), .term_lf_out(term_lf_out),
		.addr_out(addr_out), .link(u_bus_link_if.device));
	bus_ctrl_end u_bus_ctrl_end (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
		.req_in(req), .req_cmd_in(req_cmd), .srq_out(srq_out), .status_out(status_out),
		.fault_module_out(fmod), .fault_module_valid_out(fmv), .link(u_bus_link_if.controller));
	bus_link_assertions u_bus_link_assertions (.mclk_in(mclk_in), .rst_in(rst_in),
		.cmd_valid(u_bus_link_if.cmd_valid), .cmd(u_bus_link_if.cmd), .srq(u_bus_link_if.srq),
		.status_byte(u_bus_link_if.status_byte), .event_module(u_bus_link_if.event_module),
		.event_valid(u_bus_link_if.event_valid));
	// pulses are caught here so a late look still sees them
	always @(posedge mclk_in) begin
		if (nvw) s_nvw <= 1'b1;
		if (winit) s_init <= 1'b1;
		if (rest) s_rest <= 1'b1;
		if (fmv) s_mod <= 1'b1;
		if (fmv) got_mod <= fmod;
	end
	initial begin
		mclk_in = 0;
		forever #5 mclk_in = ~mclk_in;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(negedge mclk_in);
	endtask
	task automatic press(input logic m, input logic [3:0] k);
		mkey = m;
		kvalid = !m;
		key = k;
		tick(1);
		mkey = 0;
		kvalid = 0;
		tick(3);
	endtask
	task automatic send(input test_cmd_t c);
		req = 1;
		req_cmd = c;
		tick(1);
		req = 0;
		tick(3);
	endtask
	task automatic wait_srq();
		n = 0;
		while (srq_out !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		// a missing request must fail the run on its own
		if (n >= 200) begin
			n_errors++;
			$display("ERROR %0t: no service request", $time);
		end
		tick(3);
	endtask
	task automatic query(input logic [5:0] m);
		s_mod = 0;
		send(TCMD_EVENT_QUERY);
		chk(s_mod, 1);
		chk(got_mod, m);
		chk(srq_out, 0);
	endtask
	task automatic finish_check(input logic [7:0] code);
		chk(status_out, code);
		chk(s_init, 1);
		chk(s_rest, 1);
	endtask
	task automatic test_power_up();
		wait_srq();
		chk(8'(n >= 63 && n <= 70), 1);
		finish_check(`STB_OP_COMPLETE);
		chk(mode_out, MODE_TALK_ONLY);
		chk(addr_out, 5'h1D);
		chk(term_lf_out, 0);
		send(TCMD_EVENT_QUERY);
	endtask
	task automatic test_abort_running();
		send(TCMD_START);
		send(TCMD_ABORT);
		tick(30);
		chk(srq_out, 0);
		s_init = 0;
		s_rest = 0;
		wait_srq();
		finish_check(`STB_OP_COMPLETE);
		send(TCMD_EVENT_QUERY);
	endtask
	task automatic test_fault();
		fault = 1;
		send(TCMD_TEST);
		wait_srq();
		chk(status_out, `STB_INTERNAL);
		query(6'h00);
		send(TCMD_RESUME);
		wait_srq();
		chk(status_out, `STB_INTERNAL);
		query(6'h01);
		fault = 0;
		s_init = 0;
		s_rest = 0;
		send(TCMD_ABORT);
		wait_srq();
		finish_check(`STB_OP_COMPLETE);
		send(TCMD_EVENT_QUERY);
	endtask
	task automatic test_menu();
		int i;
		press(1, 0);
		chk(act, 1);
		chk(lamp, 1);
		chk(ident, 1);
		press(0, `KEY_ADDR);
		chk(edit_field_out, EDIT_ADDR);
		chk(blink, 1);
		chk(show_addr_out, 5'h1D);
		press(0, `KEY_ADDR);
		chk(show_addr_out, `ADDR_MAX);
		press(0, `KEY_ADDR);
		chk(show_addr_out, 5'h00);
		chk(addr_out, 5'h1D);
		press(0, 4'h9);
		chk(edit_field_out, EDIT_ADDR);
		press(0, `KEY_MODE);
		chk(show_mode_out, MODE_TALK_ONLY);
		chk(blink, 1);
		for (i = 0; i < 5; i++) begin
			press(0, `KEY_MODE);
			chk(show_mode_out, 8'((i + 2) % 4));
		end
		chk(show_addr_out, 5'h00);
		press(0, `KEY_TERM);
		chk(show_term_out, 0);
		press(0, `KEY_TERM);
		chk(show_term_out, 1);
		chk(mode_out, MODE_TALK_ONLY);
		s_nvw = 0;
		press(1, 0);
		chk(mode_out, MODE_LISTEN_ONLY);
		chk(term_lf_out, 1);
		chk(addr_out, 5'h00);
		chk(act, 0);
		chk(lamp, 0);
		chk(blink, 0);
		chk(ident, 0);
		chk(s_nvw, 1);
	endtask
	task automatic test_lockout();
		lock = 1;
		press(1, 0);
		press(0, `KEY_ADDR);
		press(0, `KEY_ADDR);
		chk(show_addr_out, 5'h01);
		s_nvw = 0;
		press(1, 0);
		chk(addr_out, 5'h00);
		chk(s_nvw, 0);
		chk(rej, 1);
		press(1, 0);
		chk(rej, 0);
		lock = 0;
		press(1, 0);
	endtask
	// a press while the clock enable is low must be lost
	task automatic test_freeze();
		ce_in = 0;
		press(1, 0);
		chk(act, 0);
		ce_in = 1;
		tick(2);
		chk(act, 0);
	endtask
	task automatic test_done();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#500000;
		n_errors++;
		test_done();
	end
	initial begin
		{rst_in, ce_in, mkey, kvalid, lock, fault, req, key} = {7'b1100000, 4'h0};
		nv_mode = MODE_TALK_ONLY;
		nv_term = 1'b0;
		nv_addr = 5'h1D;
		req_cmd = TCMD_NONE;
		{s_nvw, s_init, s_rest, s_mod, got_mod} = 10'h000;
		n_errors = 0;
		comparisons = 0;
		tick(10);
		rst_in = 0;
		test_power_up();
		test_abort_running();
		test_fault();
		test_menu();
		test_lockout();
		test_freeze();
		test_done();
	end
endmodule
